// ### design/ebs_top.sv
// EPROM expansion board bus slave: decode, socket enables, delays, inhibit
`timescale 1ns/100ps
module ebs_top import ebs_pkg::*; (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [ADDR_W-1:0] bus_addr_i,
    input wire logic bus_mrdc_n_i,
    input wire logic bus_bhen_n_i,
    output logic [DATA_W-1:0] bus_data_o,
    output logic bus_data_oe_o,
    output logic bus_xack_n_o,
    output logic bus_inh1_n_o,
    input wire logic [NUM_BANKS*BYTE_W-1:0] rom_data_i,
    output logic [ROM_ADDR_W-1:0] rom_addr_o,
    output logic [NUM_SOCK-1:0] sock_ce_n_o,
    output logic rom_oe_n_o,
    input wire logic cfg_mode16_i,
    input wire logic [1:0] cfg_dev_size_i,
    input wire logic [NUM_BANKS-1:0] cfg_bank_dis_i,
    input wire logic [SOCK_PER_BANK-1:0] cfg_sock_dis_i,
    input wire logic [3:0] cfg_base_a_i,
    input wire logic [3:0] cfg_base_b_i,
    input wire logic [3:0] cfg_base_c_i,
    input wire logic [3:0] cfg_base_d_i,
    input wire logic [NUM_BANKS-1:0] cfg_bank_page_i,
    input wire logic cfg_page_dec_i,
    input wire logic [3:0] cfg_page0_i,
    input wire logic [3:0] cfg_page1_i,
    input wire logic cfg_page1_en_i,
    input wire logic [3:0] cfg_acc_sel_i,
    input wire logic [NUM_BANKS-1:0] cfg_ovl_i
);

    localparam int CFG_W = 49;
    localparam int BUS_W = ADDR_W + 2;

    // Synchronised pin levels
    logic [BUS_W-1:0] bus_s;
    logic [CFG_W-1:0] cfg_s;
    logic [NUM_BANKS*BYTE_W-1:0] rom_s;
    logic [ADDR_W-1:0] addr_s;
    logic rd_s;
    logic bhen_s;
    logic mode16_s;
    logic [1:0] dsz_s;
    logic [NUM_BANKS-1:0] bank_dis_s;
    logic [SOCK_PER_BANK-1:0] sock_dis_s;
    logic [3:0] base_s [NUM_BANKS];
    logic [NUM_BANKS-1:0] bank_page_s;
    logic page_dec_s;
    logic [3:0] page0_s;
    logic [3:0] page1_s;
    logic page1_en_s;
    logic [3:0] acc_sel_s;
    logic [NUM_BANKS-1:0] ovl_s;

    // Decode results
    logic hit_c;
    logic ovl_c;
    logic [1:0] bank_c;
    logic [1:0] sock_c;
    logic lo_en_c;
    logic hi_en_c;
    logic [ROM_ADDR_W-1:0] dev_addr_c;
    logic [NUM_SOCK-1:0] ce_n_c;

    // Sequencer state
    ebs_state_t state_r;
    logic [CNT_W-1:0] cnt_r;
    logic [1:0] bank_r;
    logic hi_en_r;
    logic lo_en_r;
    logic bhen_r;
    logic [NUM_SOCK-1:0] ce_n_r;
    logic [ROM_ADDR_W-1:0] rom_addr_r;
    logic [DATA_W-1:0] data_r;
    logic inh_r;

    // Bus pins: mrdc and bhen idle high through reset
    ebs_sync #(.W(BUS_W), .RST({2'b11, {ADDR_W{1'b0}}})) u_bus_sync (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .d_i({bus_mrdc_n_i, bus_bhen_n_i, bus_addr_i}),
        .q_o(bus_s)
    );

    // Board switches and jumpers, static in use but still pins
    ebs_sync #(.W(CFG_W), .RST({CFG_W{1'b0}})) u_cfg_sync (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .d_i({cfg_mode16_i, cfg_dev_size_i, cfg_bank_dis_i, cfg_sock_dis_i,
              cfg_base_a_i, cfg_base_b_i, cfg_base_c_i, cfg_base_d_i,
              cfg_bank_page_i, cfg_page_dec_i, cfg_page0_i, cfg_page1_i,
              cfg_page1_en_i, cfg_acc_sel_i, cfg_ovl_i}),
        .q_o(cfg_s)
    );

    // EPROM data pins; the lag is added to every access count
    ebs_sync #(.W(NUM_BANKS*BYTE_W), .RST('0)) u_rom_sync (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .d_i(rom_data_i),
        .q_o(rom_s)
    );

    // Unpack synchronised groups
    assign addr_s = bus_s[ADDR_W-1:0];
    assign bhen_s = ~bus_s[ADDR_W];
    assign rd_s = ~bus_s[ADDR_W+1];
    assign {mode16_s, dsz_s, bank_dis_s, sock_dis_s,
            base_s[0], base_s[1], base_s[2], base_s[3],
            bank_page_s, page_dec_s, page0_s, page1_s,
            page1_en_s, acc_sel_s, ovl_s} = cfg_s;

    // Offset of an address above a bank base, with wide or 8K-base forms
    function automatic logic [16:0] bank_off(input logic [15:0] a,
                                              input logic [3:0] base,
                                              input logic [1:0] dsz,
                                              input logic wide);
        logic [3:0] b;
        logic [15:0] off;
        int lim;
        b = base;
        if (wide && dsz == DEV_4K) begin
            b[0] = 1'b0;
        end
        off = a - {b, 12'h000};
        lim = BASE_LSB + int'(dsz) + (wide ? 1 : 0);
        return {(off >> lim) == 16'h0000, off};
    endfunction

    // Page match for a bank, ignored when page decoding is switched off
    function automatic logic page_ok(input logic [3:0] pg, input logic sel);
        if (!page_dec_s) begin
            return 1'b1;
        end
        return sel ? (page1_en_s && pg == page1_s) : (pg == page0_s);
    endfunction

    // Address decode; lowest bank wins so no more than one bank or pair answers
    always_comb begin
        logic [16:0] r;
        logic [15:0] off;
        logic [1:0] sk;
        logic found;
        int sh;
        r = '0;
        off = '0;
        sk = '0;
        found = 1'b0;
        sh = DEV_LSB_MIN + int'(dsz_s);
        hit_c = 1'b0;
        ovl_c = 1'b0;
        bank_c = 2'h0;
        sock_c = 2'h0;
        lo_en_c = 1'b0;
        hi_en_c = 1'b0;
        dev_addr_c = '0;
        if (!mode16_s) begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                r = bank_off(addr_s[15:0], base_s[b], dsz_s, 1'b0);
                off = r[15:0];
                sk = 2'(off >> sh);
                if (!found && r[16] && !bank_dis_s[b]
                    && page_ok(addr_s[19:16], bank_page_s[b])
                    && !(b == 3 && sock_dis_s[sk])) begin
                    found = 1'b1;
                    bank_c = 2'(b);
                    sock_c = sk;
                    dev_addr_c = ROM_ADDR_W'(off & ((16'h0001 << sh) - 1));
                    ovl_c = ovl_s[b];
                end
            end
            lo_en_c = found;
        end else begin
            // Banks AB and CD carry the even byte low, odd byte high
            for (int p = 0; p < NUM_BANKS; p += 2) begin
                r = bank_off(addr_s[15:0], base_s[p], dsz_s, 1'b1);
                off = r[15:0];
                sk = 2'(off >> (sh + 1));
                if (!found && r[16] && !bank_dis_s[p]
                    && page_ok(addr_s[19:16], bank_page_s[p])
                    && !(p == 2 && sock_dis_s[sk])) begin
                    found = 1'b1;
                    bank_c = 2'(p);
                    sock_c = sk;
                    dev_addr_c = ROM_ADDR_W'((off >> 1)
                                 & ((16'h0001 << sh) - 1));
                    ovl_c = ovl_s[p] | ovl_s[p+1];
                    lo_en_c = ~addr_s[0];
                    hi_en_c = addr_s[0] | bhen_s;
                end
            end
        end
        hit_c = found;
    end

    // Socket enables: one socket, or the two of a pair for a word
    always_comb begin
        ce_n_c = CE_N_RST;
        if (lo_en_c) begin
            ce_n_c[{bank_c, sock_c}] = 1'b0;
        end
        if (hi_en_c) begin
            ce_n_c[{bank_c + 2'h1, sock_c}] = 1'b0;
        end
    end

    // Sequencer: wait out the chosen delay, then acknowledge
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (rd_s && hit_c) begin
                        state_r <= ST_WAIT;
                        cnt_r <= ovl_c ? OVL_LOAD
                                       : acc_cycles(acc_sel_s);
                    end
                end
                ST_WAIT: begin
                    if (!rd_s) begin
                        state_r <= ST_IDLE;
                    end else if (cnt_r <= CNT_W'(1)) begin
                        state_r <= ST_ACK;
                    end else begin
                        cnt_r <= cnt_r - CNT_W'(1);
                    end
                end
                ST_ACK: begin
                    // Held until the master drops the command
                    if (!rd_s) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Selection latched at request; address is held by the master anyway
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            ce_n_r <= CE_N_RST;
            rom_addr_r <= '0;
            bank_r <= 2'h0;
            hi_en_r <= 1'b0;
            lo_en_r <= 1'b0;
            bhen_r <= 1'b0;
        end else if (state_r == ST_IDLE && rd_s && hit_c) begin
            ce_n_r <= ce_n_c;
            rom_addr_r <= dev_addr_c;
            bank_r <= bank_c;
            hi_en_r <= hi_en_c;
            lo_en_r <= lo_en_c;
            bhen_r <= bhen_s;
        end else if (state_r == ST_IDLE || !rd_s) begin
            ce_n_r <= CE_N_RST;
        end
    end

    // Data capture at end of delay; steer bytes to their bus lanes
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            data_r <= DATA_RST;
        end else if (state_r == ST_WAIT && cnt_r <= CNT_W'(1)) begin
            if (hi_en_r && lo_en_r) begin
                data_r <= {rom_s[8*(bank_r+1) +: 8],
                           rom_s[8*bank_r +: 8]};
            end else if (hi_en_r) begin
                // 8-bit masters without byte-high enable take it low
                data_r <= bhen_r ? {rom_s[8*(bank_r+1) +: 8], 8'h00}
                                 : {8'h00, rom_s[8*(bank_r+1) +: 8]};
            end else if (!mode16_s && bhen_r && addr_s[0]) begin
                data_r <= {rom_s[8*bank_r +: 8], 8'h00};
            end else begin
                data_r <= {8'h00, rom_s[8*bank_r +: 8]};
            end
        end
    end

    // Inhibit follows the decoded address, not the command, so RAM
    // sees it as early as possible
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            inh_r <= 1'b0;
        end else begin
            inh_r <= hit_c && ovl_c;
        end
    end

    // Pin outputs
    assign bus_data_o = data_r;
    assign bus_data_oe_o = (state_r == ST_ACK);
    assign bus_xack_n_o = ~(state_r == ST_ACK);
    assign bus_inh1_n_o = ~inh_r;
    assign sock_ce_n_o = ce_n_r;
    assign rom_addr_o = rom_addr_r;
    assign rom_oe_n_o = (ce_n_r == CE_N_RST);

    // Checking helpers: cycles spent waiting, and the load expected
    logic [CNT_W-1:0] wait_h;
    logic [CNT_W-1:0] exp_h;
    always_ff @(posedge clock_i) begin
        if (reset_i || state_r != ST_WAIT) begin
            wait_h <= CNT_W'(1);
        end else begin
            wait_h <= wait_h + CNT_W'(1);
        end
    end
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            exp_h <= '0;
        end else if (state_r == ST_IDLE) begin
            exp_h <= ovl_c ? CNT_W'(OVL_CYCLES + SYNC_LAT)
                           : acc_cycles(acc_sel_s);
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    standby_limit_a: assert property (
        $countones(~sock_ce_n_o) <= 2)
        else $error("more than two sockets enabled");
    ack_delay_a: assert property (
        state_r == ST_WAIT ##1 state_r == ST_ACK |-> $past(wait_h) == exp_h)
        else $error("acknowledge not at selected delay");
    ovl_stretch_a: assert property (
        $rose(state_r == ST_ACK) && !bus_inh1_n_o
        |-> $past(wait_h) == OVL_LOAD)
        else $error("overlap access not stretched");
    inh_cause_a: assert property (
        !bus_inh1_n_o |-> $past(hit_c && ovl_c))
        else $error("inhibit without overlap bank");
    no_response_a: assert property (
        state_r == ST_IDLE && !hit_c |=> state_r != ST_WAIT)
        else $error("response at deselected address");
    byte_mode_a: assert property (
        state_r == ST_WAIT && !mode16_s |-> $countones(~sock_ce_n_o) == 1)
        else $error("8-bit mode must enable one socket");
    word_read_a: assert property (
        state_r == ST_WAIT && hi_en_r && lo_en_r
        |-> $countones(~sock_ce_n_o) == 2)
        else $error("word read must enable a socket pair");
    xack_hold_a: assert property (
        !bus_xack_n_o && rd_s |=> !bus_xack_n_o && bus_data_oe_o)
        else $error("acknowledge dropped while command held");
    xack_release_a: assert property (
        !bus_xack_n_o && !rd_s |=> bus_xack_n_o ##1 sock_ce_n_o == 16'hFFFF)
        else $error("acknowledge not released after command");

    byte_read_c: cover property (state_r == ST_ACK && !mode16_s);
    word_read_c: cover property (state_r == ST_ACK && hi_en_r && lo_en_r);
    ovl_read_c: cover property (state_r == ST_ACK && !bus_inh1_n_o);
    abort_c: cover property (state_r == ST_WAIT && !rd_s);

endmodule // ebs_top

// ### inc/ebs_pkg.sv
// Constants, types and helpers shared by the EPROM bus slave design
package ebs_pkg;

    // Bus and array geometry
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int NUM_BANKS = 4;
    localparam int SOCK_PER_BANK = 4;
    localparam int NUM_SOCK = 16;
    localparam int ROM_ADDR_W = 12;
    localparam int BYTE_W = 8;

    // Address field positions
    localparam int PAGE_LSB = 16;
    localparam int BASE_LSB = 12;
    localparam int DEV_LSB_MIN = 10;

    // Installed device size codes: 1K, 2K, 4K bytes
    localparam logic [1:0] DEV_1K = 2'h0;
    localparam logic [1:0] DEV_2K = 2'h1;
    localparam logic [1:0] DEV_4K = 2'h2;

    // Timing, clock at 20 MHz
    localparam int CLK_PERIOD_NS = 50;
    localparam int ACC_MIN_NS = 35;
    localparam int ACC_STEP_NS = 100;
    localparam int ACC_MAX_NS = 1435;
    localparam int ACC_STEPS = 15;
    localparam int OVL_CYCLES = 15;
    localparam int SYNC_LAT = 4; // Three stages plus the agreement filter
    localparam int CNT_W = 6;

    // Reset values of registered pin levels
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [15:0] CE_N_RST = 16'hFFFF;

    // Transfer sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_ACK = 2'b10
    } ebs_state_t;

    // Cycles for a switch-chosen access time, rounded up, plus sync lag
    function automatic logic [CNT_W-1:0] acc_cycles(input logic [3:0] sel);
        int step;
        int ns;
        step = (sel == 4'h0) ? 1 : int'(sel);
        ns = ACC_MIN_NS + ACC_STEP_NS * (step - 1);
        return CNT_W'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_LAT);
    endfunction

    // Overlap access, fixed clock count plus sync lag
    localparam logic [CNT_W-1:0] OVL_LOAD = CNT_W'(OVL_CYCLES + SYNC_LAT);

endpackage

// ### design/ebs_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module ebs_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // Shift chain; the first stage feeds only the second
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            s1_r <= RST;
            s2_r <= RST;
            s3_r <= RST;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A bit changes only once stages two and three agree
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            q_o <= RST;
        end else begin
            q_o <= (s2_r & s3_r) | (q_o & (s2_r ^ s3_r));
        end
    end

endmodule // ebs_sync

// ### tb/ebs_rom_model.sv
// Behavioural EPROM socket array driven by the board's socket enables
`timescale 1ns/100ps
module ebs_rom_model import ebs_pkg::*; (
    input wire logic [ROM_ADDR_W-1:0] rom_addr_i,
    input wire logic [NUM_SOCK-1:0] sock_ce_n_i,
    input wire logic rom_oe_n_i,
    output logic [NUM_BANKS*BYTE_W-1:0] rom_data_o
);
    // Contents: pattern of socket index and in-device address
    function automatic logic [7:0] rom_byte(input int s,
                                            input logic [11:0] a);
        return a[7:0] ^ {a[11:8], 4'h0} ^ 8'(s * 29);
    endfunction

    initial rom_data_o = '0;

    // One lane per bank; a released lane shows the inverse of its last
    // value, so stale data never passes for a fresh read
    always @(rom_addr_i or sock_ce_n_i or rom_oe_n_i) begin
        for (int b = 0; b < NUM_BANKS; b++) begin
            logic [3:0] ce;
            ce = ~sock_ce_n_i[b*4 +: 4];
            if (rom_oe_n_i || ce == 4'h0)
                rom_data_o[b*8 +: 8] = ~rom_data_o[b*8 +: 8];
            else if ($countones(ce) > 1)
                rom_data_o[b*8 +: 8] = 8'hXX;  // Contention on the lane
            else
                rom_data_o[b*8 +: 8] = rom_byte(b * 4 + $clog2(ce),
                                                rom_addr_i);
        end
    end
endmodule  // ebs_rom_model

// ### tb/tb.sv
// Self-checking bench: table of bus reads, then hand-written cases
`timescale 1ns/100ps
module tb import ebs_pkg::*;;
    typedef struct {
        logic m;
        logic [1:0] z;
        logic [3:0] c;
        logic [19:0] a;
        logic h;
        logic hit;
    } ebs_row_t;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic [19:0] addr = 20'h01000;
    logic mrdc_n = 1'b1;
    logic bhen_n = 1'b1;
    logic m16 = 1'b0;
    logic [1:0] dsz = DEV_1K;
    logic [3:0] bdis = 4'h0;
    logic [3:0] sdis = 4'h0;
    logic [3:0] base [4] = '{4'h1, 4'h4, 4'h8, 4'hC};
    logic [3:0] bpage = 4'h0;
    logic pdec = 1'b0;
    logic [3:0] pg0 = 4'h0;
    logic [3:0] pg1 = 4'h0;
    logic pg1en = 1'b0;
    logic [3:0] acc = 4'h1;
    logic [3:0] ovl = 4'h0;
    logic [15:0] data, ce_n, sce;
    logic oe, xack_n, inh_n, roe_n, sinh, sinh0;
    logic [31:0] rdata;
    logic [11:0] raddr, sra;
    int n_fail = 0;
    int compares = 0;

    ebs_top uut (.clock_i(clock_i), .reset_i(reset_i), .bus_addr_i(addr),
        .bus_mrdc_n_i(mrdc_n), .bus_bhen_n_i(bhen_n), .bus_data_o(data),
        .bus_data_oe_o(oe), .bus_xack_n_o(xack_n), .bus_inh1_n_o(inh_n),
        .rom_data_i(rdata), .rom_addr_o(raddr), .sock_ce_n_o(ce_n),
        .rom_oe_n_o(roe_n), .cfg_mode16_i(m16), .cfg_dev_size_i(dsz),
        .cfg_bank_dis_i(bdis), .cfg_sock_dis_i(sdis),
        .cfg_base_a_i(base[0]), .cfg_base_b_i(base[1]),
        .cfg_base_c_i(base[2]), .cfg_base_d_i(base[3]),
        .cfg_bank_page_i(bpage), .cfg_page_dec_i(pdec), .cfg_page0_i(pg0),
        .cfg_page1_i(pg1), .cfg_page1_en_i(pg1en), .cfg_acc_sel_i(acc),
        .cfg_ovl_i(ovl));
    ebs_rom_model rom (.rom_addr_i(raddr), .sock_ce_n_i(ce_n),
        .rom_oe_n_i(roe_n), .rom_data_o(rdata));

    // 20 MHz clock
    initial begin
        forever #(CLK_PERIOD_NS / 2) clock_i = ~clock_i;
    end

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Verdict: one count line, then the outcome
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Reference decode; lowest bank wins where ranges overlap
    function automatic logic dec(input logic [19:0] a, output int s,
                                 output logic [11:0] da, output int bk);
        int sz, off, n;
        logic [3:0] bb;
        sz = 1024 << dsz;
        for (int b = 0; b < 4; b += (m16 ? 2 : 1)) begin
            bb = base[b];
            if (m16 && dsz == DEV_4K) bb[0] = 1'b0;
            off = int'(a[15:0]) - int'(bb) * 4096;
            if (bdis[b] || off < 0 || off >= sz * (m16 ? 8 : 4)) continue;
            if (pdec && a[19:16] != (bpage[b] ? pg1 : pg0)) continue;
            if (pdec && bpage[b] && !pg1en) continue;
            n = m16 ? off / (2 * sz) : off / sz;
            if ((b == 3 || (m16 && b == 2)) && sdis[n]) return 1'b0;
            s = b * 4 + n;
            da = 12'(m16 ? (off >> 1) % sz : off % sz);
            bk = b;
            return 1'b1;
        end
        return 1'b0;
    endfunction

    // Bus read: address set up first, command held until acknowledge seen;
    // entered and left at a falling edge
    task automatic rd(input logic [19:0] a, input logic bh, output int lat,
                      output logic [15:0] d);
        lat = -1;
        addr = a;
        bhen_n = bh;
        repeat (6) @(negedge clock_i);
        sinh0 = inh_n;
        mrdc_n = 1'b0;
        for (int i = 1; i <= 60 && lat < 0; i++) begin
            @(posedge clock_i);
            #1;
            if (xack_n === 1'b0) lat = i;
        end
        d = data;
        sce = ce_n;
        sra = raddr;
        sinh = inh_n;
        repeat (3) @(posedge clock_i);
        #1;
        if (lat > 0) check({oe, xack_n, roe_n, data}, {3'h4, d});
        @(negedge clock_i);
        mrdc_n = 1'b1;
        repeat (8) @(negedge clock_i);
        check(xack_n, 1'b1);
        check({roe_n, ce_n}, 17'h1FFFF);
    endtask

    // One read judged against the reference decode and delay
    task automatic row(input logic [19:0] a, input logic bh, input logic eh);
        int s = 0;
        int bk = 0;
        int lat, n;
        logic [11:0] da;
        logic [15:0] d, e, m;
        logic [7:0] lo, hi;
        logic ov;
        if (!dec(a, s, da, bk)) bk = 0;
        rd(a, bh, lat, d);
        if (!eh) begin
            check(32'(lat), 32'hFFFFFFFF);
            check(sinh, 1'b1);
            return;
        end
        ov = m16 ? ovl[bk] | ovl[bk | 1] : ovl[bk];
        n = (acc == 4'h0) ? 1 : int'(acc);
        // Data pins lag four edges behind the socket enables
        n = ov ? OVL_CYCLES + SYNC_LAT
               : (ACC_MIN_NS + ACC_STEP_NS * (n - 1) + CLK_PERIOD_NS - 1)
                 / CLK_PERIOD_NS + SYNC_LAT;
        check(32'(lat >= n + 3 && lat <= n + 5), 32'h1);
        check({sinh0, sinh}, {2{!ov}});
        check(sra, da);
        check(32'($countones(~sce) <= (m16 ? 2 : 1)), 32'h1);
        // Odd paired reads enable only the high-lane socket
        check(sce[s + ((m16 && a[0]) ? 4 : 0)], 1'b0);
        lo = rom.rom_byte(s, da);
        hi = rom.rom_byte(s + 4, da);
        e = {lo, lo};
        m = (a[0] && !bh) ? 16'hFF00 : 16'h00FF;
        if (m16) begin
            e = a[0] ? {hi, hi} : {hi, lo};
            m = bh ? 16'h00FF : (a[0] ? 16'hFF00 : 16'hFFFF);
        end
        check(d & m, e & m);
        if (m == 16'hFFFF) check(sce[s + 4], 1'b0);
    endtask

    // Hang guard, well beyond the expected run
    initial begin
        #(CLK_PERIOD_NS * 20000);
        n_fail++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        ebs_row_t rows [13] = '{
            '{1'h0, 2'h0, 4'h1, 20'h01000, 1'h1, 1'h1},
            '{1'h0, 2'h0, 4'hF, 20'h01FFF, 1'h1, 1'h1},
            '{1'h0, 2'h0, 4'h2, 20'h02000, 1'h1, 1'h0},
            '{1'h0, 2'h1, 4'h0, 20'h04801, 1'h0, 1'h1},
            '{1'h0, 2'h1, 4'h3, 20'h09235, 1'h1, 1'h1},
            '{1'h0, 2'h2, 4'h4, 20'h0FFFF, 1'h1, 1'h1},
            '{1'h0, 2'h1, 4'h1, 20'h00FFF, 1'h1, 1'h0},
            '{1'h1, 2'h0, 4'h5, 20'h01000, 1'h0, 1'h1},
            '{1'h1, 2'h1, 4'h6, 20'h01FFE, 1'h1, 1'h1},
            '{1'h1, 2'h1, 4'h7, 20'h08003, 1'h0, 1'h1},
            '{1'h1, 2'h2, 4'h8, 20'h0F001, 1'h1, 1'h1},
            '{1'h1, 2'h2, 4'h1, 20'h00800, 1'h0, 1'h1},
            '{1'h1, 2'h0, 4'h1, 20'h09000, 1'h0, 1'h1}};
        int k;
        // Command asserted at a hit address while reset is held
        mrdc_n = 1'b0;
        repeat (15) @(negedge clock_i);
        check({xack_n, inh_n, oe, roe_n}, 4'hD);
        check(ce_n, 16'hFFFF);
        check({raddr, data}, {12'h000, 16'h0000});
        mrdc_n = 1'b1;
        @(negedge clock_i);
        reset_i = 1'b0;
        // Table of reads over modes, sizes, lanes and delays
        foreach (rows[i]) begin
            m16 = rows[i].m;
            dsz = rows[i].z;
            acc = rows[i].c;
            row(rows[i].a, rows[i].h, rows[i].hit);
        end
        m16 = 1'b0;
        dsz = DEV_1K;
        for (k = 9; k < 15; k++) begin
            acc = 4'(k);
            row(20'h01004, 1'b1, 1'b1);
        end
        // Bank and bank D socket deselection, 8-bit organisation
        dsz = DEV_2K;
        acc = 4'h1;
        bdis = 4'h2;
        row(20'h04000, 1'b1, 1'b0);
        bdis = 4'h0;
        sdis = 4'h4;
        row(20'h0D000, 1'b1, 1'b0);
        row(20'h0C800, 1'b1, 1'b1);
        // Paired banks: unused bit ignored, one CD pair socket and whole AB off
        m16 = 1'b1;
        dsz = DEV_1K;
        bdis = 4'h2;
        sdis = 4'h2;
        row(20'h01000, 1'b0, 1'b1);
        row(20'h08800, 1'b0, 1'b0);
        row(20'h08000, 1'b0, 1'b1);
        bdis = 4'h1;
        sdis = 4'h0;
        row(20'h01000, 1'b0, 1'b0);
        bdis = 4'h0;
        // Two pages, bank C living in the second
        m16 = 1'b0;
        dsz = DEV_2K;
        pdec = 1'b1;
        pg0 = 4'h3;
        pg1 = 4'h9;
        pg1en = 1'b1;
        bpage = 4'h4;
        row(20'h31000, 1'b1, 1'b1);
        row(20'h01000, 1'b1, 1'b0);
        row(20'h98000, 1'b1, 1'b1);
        row(20'h38000, 1'b1, 1'b0);
        pdec = 1'b0;
        // Overlap stretches the access and inhibits RAM
        ovl = 4'h1;
        row(20'h01000, 1'b1, 1'b1);
        m16 = 1'b1;
        ovl = 4'h2;
        row(20'h01000, 1'b0, 1'b1);
        ovl = 4'h0;
        // Command withdrawn mid-wait: no acknowledge, enables drop
        m16 = 1'b0;
        acc = 4'hF;
        addr = 20'h01000;
        repeat (6) @(negedge clock_i);
        mrdc_n = 1'b0;
        repeat (10) @(negedge clock_i);
        mrdc_n = 1'b1;
        k = 0;
        repeat (60) begin
            @(negedge clock_i);
            if (xack_n !== 1'b1) k++;
        end
        check(32'(k), 32'h0);
        check(ce_n, 16'hFFFF);
        row(20'h01000, 1'b1, 1'b1);
        tally_and_finish();
    end
endmodule  // tb
